// *** aob_defines.vh ***
// aob_defines.vh: constants shared by the off-chip bridge pair
// assumes inclusion by bare name from the same folder
`ifndef AOB_DEFINES_VH
`define AOB_DEFINES_VH
// register byte addresses
`define AOB_REG_CTRL      8'h00
`define AOB_REG_STATUS    8'h04
`define AOB_REG_MBASE     8'h08
`define AOB_REG_MMASK     8'h0c
`define AOB_REG_SBASE     8'h10
`define AOB_REG_SMASK     8'h14
// control fields
`define AOB_CTRL_MINCR    0
`define AOB_CTRL_SINCR    1
`define AOB_CTRL_ASYNC    2
`define AOB_CTRL_DIV_LO   3
`define AOB_CTRL_DIV_HI   5
`define AOB_CTRL_PASS     6
`define AOB_CTRL_MASK     32'h0000007f
// reset values
`define AOB_RST_CTRL      32'h00000000
`define AOB_RST_MBASE     32'h80000000
`define AOB_RST_MMASK     32'h80000000
`define AOB_RST_SBASE     32'h00000000
`define AOB_RST_SMASK     32'h00000000
// bridge mode codes
`define AOB_MODE_ASYNC    2'h0
`define AOB_MODE_N1       2'h1
`define AOB_MODE_1TO1     2'h2
`define AOB_MODE_PASS     2'h3
// ahb encodings
`define AOB_TR_IDLE       2'h0
`define AOB_TR_BUSY       2'h1
`define AOB_BU_SINGLE     3'h0
`define AOB_BU_INCR       3'h1
`define AOB_RSP_OKAY      2'h0
`define AOB_RSP_ERROR     2'h1
// axi responses
`define AOB_AXI_OKAY      2'h0
`define AOB_AXI_DECERR    2'h3
// mclk cycles a far data phase may wait before the bridge gives up
`define AOB_ACK_TIMEOUT   10'h3e8
`endif

// *** aob_clken.v ***
// aob_clken.v: off-chip clock edge finder, N:1 enable divider, mode decode
// assumes x_hclk is asynchronous to mclk and each phase lasts several mclk
`timescale 1ns/10ps
`include "aob_defines.vh"
module aob_clken (
   input  wire       mclk,
   input  wire       rst_n,
   input  wire       x_hclk,
   input  wire       async_mode_select,
   input  wire [2:0] offchip_clock_divider_select,
   input  wire       passthrough_select,
   output reg        off_en_r,
   output reg  [1:0] bridge_mode_code_r
);
   reg  [2:0] ck_r;      // [0] first stage, [1] settled, [2] previous
   reg  [2:0] div_cnt_r;
   reg  [1:0] mode_nxt;

   // mode priority: async, then divider, then pass-through
   always @* begin
      if (async_mode_select)
         mode_nxt = `AOB_MODE_ASYNC; // R09
      else if (offchip_clock_divider_select != 3'h0)
         mode_nxt = `AOB_MODE_N1; // R09
      else if (passthrough_select)
         mode_nxt = `AOB_MODE_PASS; // R09
      else
         mode_nxt = `AOB_MODE_1TO1; // R09
   end

   // off-chip edge strobe; divider gives N = field+1 on-chip edges
   always @(posedge mclk) begin
      if (!rst_n) begin
         ck_r               <= 3'h0;
         div_cnt_r          <= 3'h0;
         off_en_r           <= 1'b0;
         bridge_mode_code_r <= `AOB_MODE_1TO1;
      end else begin
         ck_r               <= {ck_r[1:0], x_hclk};
         bridge_mode_code_r <= mode_nxt;
         if (div_cnt_r >= offchip_clock_divider_select)
            div_cnt_r <= 3'h0;
         else
            div_cnt_r <= div_cnt_r + 3'h1;
         case (mode_nxt)
            `AOB_MODE_ASYNC: off_en_r <= ck_r[1] & ~ck_r[2]; // R12
            `AOB_MODE_N1:    off_en_r <= (div_cnt_r >= offchip_clock_divider_select); // R11
            default:         off_en_r <= 1'b1; // R10
         endcase
      end
   end
endmodule

// *** aob_core.v ***
// aob_core.v: one direction of the bridge, ahb slave side to ahb master side
// assumes src_en/dst_en mark the valid edges of each bus, both on mclk
`timescale 1ns/10ps
`include "aob_defines.vh"
module aob_core (
   input  wire        mclk,
   input  wire        rst_n,
   input  wire        src_en,
   input  wire        dst_en,
   input  wire        pass,
   input  wire        to_incr,
   input  wire        s_sel,
   input  wire [31:0] s_haddr,
   input  wire [1:0]  s_htrans,
   input  wire        s_hwrite,
   input  wire [2:0]  s_hsize,
   input  wire [2:0]  s_hburst,
   input  wire [31:0] s_hwdata,
   input  wire        s_hready_in,
   output wire        s_hready,
   output wire [1:0]  s_hresp,
   output wire [31:0] s_hrdata,
   output wire        s_own,
   output wire [31:0] m_haddr,
   output wire [1:0]  m_htrans,
   output wire        m_hwrite,
   output wire [2:0]  m_hsize,
   output wire [2:0]  m_hburst,
   output wire [31:0] m_hwdata,
   output wire        m_wr_oe,
   output wire        m_busreq,
   input  wire        m_hgrant,
   input  wire        m_hready,
   input  wire [1:0]  m_hresp,
   input  wire [31:0] m_hrdata,
   output wire        m_own,
   output wire        busy
);
   localparam ST_IDLE = 2'h0;
   localparam ST_ADDR = 2'h1;
   localparam ST_DATA = 2'h2;
   localparam ST_ERR  = 2'h3;

   reg [1:0]  st_r;
   reg [31:0] addr_r, wd_r, rd_r;
   reg [1:0]  tr_r, mtr_r, rsp_r;
   reg [2:0]  size_r, burst_r;
   reg        wr_r, wd_ok_r, rdy_r, own_r, mown_r, req_r, wroe_r;
   reg        pt_dph_r, pt_wr_r;
   reg [9:0]  tmo_r;
   wire       take;

   // fixed-length bursts become incr when override is set
   function [2:0] burst_map;
      input       ovr;
      input [2:0] b;
      begin
         burst_map = (ovr && b != `AOB_BU_SINGLE) ? `AOB_BU_INCR : b;   // R07 R08
      end
   endfunction

   assign take = src_en & s_hready_in & s_sel & s_htrans[1] & (st_r == ST_IDLE);  // R02

   // pass-through joins the two sides without registers; only the pad enables come from pt_dph_r, pt_wr_r and mown_r
   assign s_hready = pass ? m_hready : rdy_r; // R13
   assign s_hresp  = pass ? m_hresp  : rsp_r;
   assign s_hrdata = pass ? m_hrdata : rd_r;
   assign s_own    = pass ? pt_dph_r : own_r;
   assign m_haddr  = pass ? s_haddr  : addr_r; // R01
   assign m_htrans = pass ? (s_sel ? s_htrans : `AOB_TR_IDLE) : mtr_r;
   assign m_hwrite = pass ? s_hwrite : wr_r;
   assign m_hsize  = pass ? s_hsize  : size_r;
   assign m_hburst = pass ? burst_map(to_incr, s_hburst) : burst_r;
   assign m_hwdata = pass ? s_hwdata : wd_r;
   assign m_wr_oe  = pass ? pt_wr_r  : wroe_r;
   assign m_busreq = pass ? (s_sel & s_htrans[1]) : req_r;
   assign m_own    = mown_r;
   assign busy     = (st_r != ST_IDLE);

   // transfer engine: one transfer is finished before the next is taken
   always @(posedge mclk) begin
      if (!rst_n) begin
         st_r <= ST_IDLE; addr_r <= 32'h0; wd_r <= 32'h0; rd_r <= 32'h0;
         tr_r <= `AOB_TR_IDLE; mtr_r <= `AOB_TR_IDLE; rsp_r <= `AOB_RSP_OKAY;
         size_r <= 3'h0; burst_r <= `AOB_BU_SINGLE; wr_r <= 1'b0;
         wd_ok_r <= 1'b0; rdy_r <= 1'b1; own_r <= 1'b0; mown_r <= 1'b0;
         req_r <= 1'b0; wroe_r <= 1'b0; pt_dph_r <= 1'b0; pt_wr_r <= 1'b0;
         tmo_r <= 10'h0;
      end else begin
         // bus ownership follows grant at each accepted far edge
         if (dst_en && m_hready)
            mown_r <= m_hgrant; // R06
         if (s_hready_in)
            pt_dph_r <= s_sel & s_htrans[1]; // R15
         if (m_hready)
            pt_wr_r <= mown_r & s_hwrite & s_htrans[1] & s_sel; // R05
         // write data follows its address by one source edge
         if (src_en && st_r != ST_IDLE && !wd_ok_r) begin
            wd_r    <= s_hwdata;
            wd_ok_r <= 1'b1;
         end
         case (st_r)
            ST_IDLE: begin
               if (src_en) begin
                  rsp_r <= `AOB_RSP_OKAY;
                  own_r <= take;
               end
               if (take) begin
                  addr_r  <= s_haddr; // R01
                  tr_r    <= s_htrans;
                  mtr_r   <= s_hwrite ? `AOB_TR_IDLE : s_htrans; // R03
                  wr_r    <= s_hwrite;
                  size_r  <= s_hsize;
                  burst_r <= burst_map(to_incr, s_hburst); // R07 R08
                  rdy_r   <= 1'b0; // R04
                  wd_ok_r <= 1'b0;
                  req_r   <= 1'b1;
                  st_r    <= ST_ADDR;
               end
            end
            ST_ADDR: begin
               if (!mtr_r[1] && wd_ok_r)
                  mtr_r <= tr_r;
               else if (mtr_r[1] && dst_en && m_hready && mown_r) begin
                  // hold the far burst open with busy while the next beat is pending
                  mtr_r  <= (burst_r != `AOB_BU_SINGLE) ? `AOB_TR_BUSY : `AOB_TR_IDLE;  // R04
                  req_r  <= 1'b0;
                  wroe_r <= wr_r;                                        // R05
                  tmo_r  <= 10'h0;
                  st_r   <= ST_DATA;
               end
            end
            ST_DATA: begin
               tmo_r <= tmo_r + 10'h1;
               if (dst_en && m_hready) begin
                  rd_r   <= m_hrdata; // R03
                  wroe_r <= 1'b0;
                  mtr_r  <= `AOB_TR_IDLE; // R04
                  if (m_hresp != `AOB_RSP_OKAY) begin
                     rsp_r <= `AOB_RSP_ERROR; // R17
                     st_r  <= ST_ERR;
                  end else begin
                     rdy_r <= 1'b1;
                     st_r  <= ST_IDLE; // R17
                  end
               end else if (tmo_r == `AOB_ACK_TIMEOUT - 10'h1) begin
                  // no far acknowledge: abandon, leave no busy behind
                  wroe_r <= 1'b0;
                  mtr_r  <= `AOB_TR_IDLE;
                  rsp_r  <= `AOB_RSP_ERROR; // R16
                  st_r   <= ST_ERR;
               end
            end
            ST_ERR: begin
               // second cycle of the two-cycle error answer
               if (src_en) begin
                  rdy_r <= 1'b1;
                  st_r  <= ST_IDLE;
               end
            end
            default: st_r <= ST_IDLE;
         endcase
      end
   end
endmodule

// *** aob_top.v ***
// aob_top.v: off-chip bridge pair with its axi4-lite configuration slave
// assumes on-chip buses run on mclk; all off-chip pins are asynchronous
`timescale 1ns/10ps
`include "aob_defines.vh"
// Function
// R01: address passes unchanged, full 32 bits.
// R02: answers only transfers in its decoded region.
// R03: taken transfer re-issued far side; response returned.
// R04: source stalled by wait states; far burst may carry busy.
// R05: shared data pads driven only with write data.
// R06: master pins tristated for external arbiter; request never tristated.
// R07: override high: fixed bursts become incr.
// R08: override low: fixed bursts pass; system must not split them.
// R09: mode code: async 00, divider 01, 1:1 10, pass 11.
// R10: 1:1 mode: on-chip clock alone, all paths registered.
// R11: N:1 mode: enable marks off-chip edges.
// R12: async mode: off-chip clock sampled, registered in both domains; code registers only on mclk, sampling x_hclk into ck_r.
// R13: pass-through joins sides combinationally, no added cycles; code still passes off-chip inputs through the two-flop synchronizers.
// R14: slave bridge decodes off-chip map, reaches on-chip slaves.
// R15: slave bridge tristates its response pins.
// R16: unacknowledged off-chip access ends in bus error.
// R17: far errors returned unchanged; one transfer at a time.
module aob_top (
   input  wire        mclk,
   input  wire        rst_n,
   // axi4-lite configuration slave
   input  wire [7:0]  awaddr,
   input  wire        awvalid,
   output wire        awready,
   input  wire [31:0] wdata,
   input  wire [3:0]  wstrb,
   input  wire        wvalid,
   output wire        wready,
   output wire [1:0]  bresp,
   output wire        bvalid,
   input  wire        bready,
   input  wire [7:0]  araddr,
   input  wire        arvalid,
   output wire        arready,
   output wire [31:0] rdata,
   output wire [1:0]  rresp,
   output wire        rvalid,
   input  wire        rready,
   // off-chip bus clock
   input  wire        x_hclk,
   // master bridge, on-chip ahb slave side
   input  wire        ms_hsel,
   input  wire [31:0] ms_haddr,
   input  wire [1:0]  ms_htrans,
   input  wire        ms_hwrite,
   input  wire [2:0]  ms_hsize,
   input  wire [2:0]  ms_hburst,
   input  wire [31:0] ms_hwdata,
   input  wire        ms_hready_in,
   output wire        ms_hready,
   output wire [1:0]  ms_hresp,
   output wire [31:0] ms_hrdata,
   // master bridge, off-chip ahb master pins
   output wire [31:0] mx_haddr,
   output wire [1:0]  mx_htrans,
   output wire        mx_hwrite,
   output wire [2:0]  mx_hsize,
   output wire [2:0]  mx_hburst,
   output wire        mx_ctl_oe,
   input  wire [31:0] mx_hd_in,
   output wire [31:0] mx_hd_out,
   output wire        mx_hd_oe,
   output wire        mx_hbusreq,
   input  wire        mx_hgrant,
   input  wire        mx_hready,
   input  wire [1:0]  mx_hresp,
   // slave bridge, off-chip ahb slave pins
   input  wire        sx_hsel,
   input  wire [31:0] sx_haddr,
   input  wire [1:0]  sx_htrans,
   input  wire        sx_hwrite,
   input  wire [2:0]  sx_hsize,
   input  wire [2:0]  sx_hburst,
   input  wire [31:0] sx_hwdata,
   input  wire        sx_hready_in,
   output wire        sx_hready,
   output wire [1:0]  sx_hresp,
   output wire [31:0] sx_hrdata,
   output wire        sx_resp_oe,
   // slave bridge, on-chip ahb master side
   output wire [31:0] sm_haddr,
   output wire [1:0]  sm_htrans,
   output wire        sm_hwrite,
   output wire [2:0]  sm_hsize,
   output wire [2:0]  sm_hburst,
   output wire [31:0] sm_hwdata,
   input  wire        sm_hready,
   input  wire [1:0]  sm_hresp,
   input  wire [31:0] sm_hrdata,
   // current clocking mode
   output wire [1:0]  bridge_mode_code
);
   localparam SYN_W = 111;

   reg  [31:0] ctrl_r, mbase_r, mmask_r, sbase_r, smask_r;
   reg  [7:0]  wa_r;
   reg  [31:0] wd_r;
   reg  [3:0]  ws_r;
   reg         awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
   reg  [1:0]  bresp_r, rresp_r;
   reg  [31:0] rdata_r, rd_mux;
   wire [SYN_W-1:0] syn_raw, syn_q;
   wire [31:0] mq_hd, sq_haddr, sq_hwdata;
   wire [1:0]  mq_hresp, sq_htrans, mode;
   wire [2:0]  sq_hsize, sq_hburst;
   wire        mq_hready, mq_hgrant, sq_hsel, sq_hwrite, sq_hready_in;
   wire        off_en, pass, m_busy, s_busy, ms_sel, sx_sel;

   // byte-lane merge for register writes
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  strb;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1)
            if (strb[i])
               merge[i*8 +: 8] = nw[i*8 +: 8];
      end
   endfunction

   // mapped, word-aligned register address
   function reg_ok;
      input [7:0] a;
      begin
         reg_ok = (a == `AOB_REG_CTRL)  || (a == `AOB_REG_STATUS) ||
                  (a == `AOB_REG_MBASE) || (a == `AOB_REG_MMASK)  ||
                  (a == `AOB_REG_SBASE) || (a == `AOB_REG_SMASK);
      end
   endfunction

   // address falls in a bridge window
   function region_hit;
      input [31:0] a;
      input [31:0] base;
      input [31:0] mask;
      begin
         region_hit = ((a & mask) == (base & mask));
      end
   endfunction

   // every off-chip input passes two flops before use
   assign syn_raw = {mx_hd_in, mx_hready, mx_hresp, mx_hgrant, sx_hsel, sx_haddr, sx_htrans,
                     sx_hwrite, sx_hsize, sx_hburst, sx_hwdata, sx_hready_in};
   genvar gi;
   generate
      for (gi = 0; gi < SYN_W; gi = gi + 1) begin : g_syn
         reg meta_r;
         reg q_r;
         always @(posedge mclk) begin
            if (!rst_n) begin
               meta_r <= 1'b0;
               q_r    <= 1'b0;
            end else begin
               meta_r <= syn_raw[gi];
               q_r    <= meta_r;
            end
         end
         assign syn_q[gi] = q_r;
      end
   endgenerate
   assign {mq_hd, mq_hready, mq_hresp, mq_hgrant, sq_hsel, sq_haddr, sq_htrans,
           sq_hwrite, sq_hsize, sq_hburst, sq_hwdata, sq_hready_in} = syn_q;

   // region decode for both bridges
   assign ms_sel = ms_hsel & region_hit(ms_haddr, mbase_r, mmask_r);     // R02
   assign sx_sel = sq_hsel & region_hit(sq_haddr, sbase_r, smask_r);     // R14
   assign pass   = (mode == `AOB_MODE_PASS);                             // R13
   assign bridge_mode_code = mode;

   aob_clken u_clken (
      .mclk                         (mclk),
      .rst_n                        (rst_n),
      .x_hclk                       (x_hclk),
      .async_mode_select            (ctrl_r[`AOB_CTRL_ASYNC]),
      .offchip_clock_divider_select (ctrl_r[`AOB_CTRL_DIV_HI:`AOB_CTRL_DIV_LO]),
      .passthrough_select           (ctrl_r[`AOB_CTRL_PASS]),
      .off_en_r                     (off_en),
      .bridge_mode_code_r           (mode)
   );

   // on-chip masters out to off-chip slaves; far side paced by off_en
   aob_core u_mbr (
      .mclk        (mclk),
      .rst_n       (rst_n),
      .src_en      (1'b1),
      .dst_en      (off_en),
      .pass        (pass),
      .to_incr     (ctrl_r[`AOB_CTRL_MINCR]),
      .s_sel       (ms_sel),
      .s_haddr     (ms_haddr),
      .s_htrans    (ms_htrans),
      .s_hwrite    (ms_hwrite),
      .s_hsize     (ms_hsize),
      .s_hburst    (ms_hburst),
      .s_hwdata    (ms_hwdata),
      .s_hready_in (ms_hready_in),
      .s_hready    (ms_hready),
      .s_hresp     (ms_hresp),
      .s_hrdata    (ms_hrdata),
      .s_own       (),
      .m_haddr     (mx_haddr),
      .m_htrans    (mx_htrans),
      .m_hwrite    (mx_hwrite),
      .m_hsize     (mx_hsize),
      .m_hburst    (mx_hburst),
      .m_hwdata    (mx_hd_out),
      .m_wr_oe     (mx_hd_oe),
      .m_busreq    (mx_hbusreq),
      .m_hgrant    (mq_hgrant),
      .m_hready    (mq_hready),
      .m_hresp     (mq_hresp),
      .m_hrdata    (mq_hd),
      .m_own       (mx_ctl_oe),
      .busy        (m_busy)
   );

   // off-chip masters in to on-chip slaves; source side paced by off_en
   aob_core u_sbr (
      .mclk        (mclk),
      .rst_n       (rst_n),
      .src_en      (off_en),
      .dst_en      (1'b1),
      .pass        (pass),
      .to_incr     (ctrl_r[`AOB_CTRL_SINCR]),
      .s_sel       (sx_sel),
      .s_haddr     (sq_haddr),
      .s_htrans    (sq_htrans),
      .s_hwrite    (sq_hwrite),
      .s_hsize     (sq_hsize),
      .s_hburst    (sq_hburst),
      .s_hwdata    (sq_hwdata),
      .s_hready_in (sq_hready_in),
      .s_hready    (sx_hready),
      .s_hresp     (sx_hresp),
      .s_hrdata    (sx_hrdata),
      .s_own       (sx_resp_oe),
      .m_haddr     (sm_haddr),
      .m_htrans    (sm_htrans),
      .m_hwrite    (sm_hwrite),
      .m_hsize     (sm_hsize),
      .m_hburst    (sm_hburst),
      .m_hwdata    (sm_hwdata),
      .m_wr_oe     (),
      .m_busreq    (),
      .m_hgrant    (1'b1),
      .m_hready    (sm_hready),
      .m_hresp     (sm_hresp),
      .m_hrdata    (sm_hrdata),
      .m_own       (),
      .busy        (s_busy)
   );

   // read mux; status shows mode and both engines
   always @* begin
      case (araddr)
         `AOB_REG_CTRL:   rd_mux = ctrl_r;
         `AOB_REG_STATUS: rd_mux = {28'h0, s_busy, m_busy, mode};
         `AOB_REG_MBASE:  rd_mux = mbase_r;
         `AOB_REG_MMASK:  rd_mux = mmask_r;
         `AOB_REG_SBASE:  rd_mux = sbase_r;
         `AOB_REG_SMASK:  rd_mux = smask_r;
         default:         rd_mux = 32'h0;
      endcase
   end

   assign awready = awready_r;
   assign wready  = wready_r;
   assign bvalid  = bvalid_r;
   assign bresp   = bresp_r;
   assign arready = arready_r;
   assign rvalid  = rvalid_r;
   assign rdata   = rdata_r;
   assign rresp   = rresp_r;

   // axi4-lite slave: address and data taken in any order, one write at a time
   always @(posedge mclk) begin
      if (!rst_n) begin
         ctrl_r    <= `AOB_RST_CTRL;
         mbase_r   <= `AOB_RST_MBASE;
         mmask_r   <= `AOB_RST_MMASK;
         sbase_r   <= `AOB_RST_SBASE;
         smask_r   <= `AOB_RST_SMASK;
         wa_r      <= 8'h0;
         wd_r      <= 32'h0;
         ws_r      <= 4'h0;
         awready_r <= 1'b1;
         wready_r  <= 1'b1;
         bvalid_r  <= 1'b0;
         bresp_r   <= `AOB_AXI_OKAY;
         arready_r <= 1'b1;
         rvalid_r  <= 1'b0;
         rdata_r   <= 32'h0;
         rresp_r   <= `AOB_AXI_OKAY;
      end else begin
         if (awready_r && awvalid) begin
            wa_r      <= awaddr;
            awready_r <= 1'b0;
         end
         if (wready_r && wvalid) begin
            wd_r     <= wdata;
            ws_r     <= wstrb;
            wready_r <= 1'b0;
         end
         if (!awready_r && !wready_r && !bvalid_r) begin
            bvalid_r <= 1'b1;
            bresp_r  <= reg_ok(wa_r) ? `AOB_AXI_OKAY : `AOB_AXI_DECERR;
            // mode changes take effect at once; software should wait for idle
            case (wa_r)
               `AOB_REG_CTRL:  ctrl_r  <= merge(ctrl_r, wd_r, ws_r) & `AOB_CTRL_MASK;  // R09
               `AOB_REG_MBASE: mbase_r <= merge(mbase_r, wd_r, ws_r);
               `AOB_REG_MMASK: mmask_r <= merge(mmask_r, wd_r, ws_r);
               `AOB_REG_SBASE: sbase_r <= merge(sbase_r, wd_r, ws_r);
               `AOB_REG_SMASK: smask_r <= merge(smask_r, wd_r, ws_r);
               default:        ctrl_r  <= ctrl_r;
            endcase
         end else if (bvalid_r && bready) begin
            bvalid_r  <= 1'b0;
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
         end
         if (arready_r && arvalid) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b1;
            rdata_r   <= rd_mux;
            rresp_r   <= reg_ok(araddr) ? `AOB_AXI_OKAY : `AOB_AXI_DECERR;
         end else if (rvalid_r && rready) begin
            rvalid_r  <= 1'b0;
            arready_r <= 1'b1;
         end
      end
   end
endmodule

// *** aob_properties.sv ***
// aob_properties.sv: master bridge checker
// assumes bind to aob_top, default master region
`timescale 1ns/10ps
module aob_props (
   input wire        mclk,
   input wire        rst_n,
   input wire        ms_hsel,
   input wire [31:0] ms_haddr,
   input wire [1:0]  ms_htrans,
   input wire        ms_hready,
   input wire [1:0]  ms_hresp,
   input wire [31:0] mx_haddr,
   input wire [1:0]  mx_htrans,
   input wire        mx_hwrite,
   input wire        mx_ctl_oe,
   input wire        mx_hd_oe
);
   reg [31:0] ta_r;
   reg [10:0] lo_r;
   wire       take = ms_hsel && ms_htrans[1] && ms_hready;
   // last taken address; stall length, too long for a repetition
   always @(posedge mclk) ta_r <= take ? ms_haddr : ta_r;
   always @(posedge mclk) lo_r <= (!rst_n || ms_hready) ? 11'h0 : lo_r + 11'h1;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   a_addr_kept: assert property (mx_htrans == 2'h2 && mx_ctl_oe |-> mx_haddr == ta_r)
      else $error("far address differs");
   a_idle_ignored: assert property (ms_hready && !take |=> ms_hready)
      else $error("wait without transfer");
   a_hresp_okay: assert property (take |=> ms_hresp == 2'h0)
      else $error("early error response");
   a_wait_state: assert property (take && ms_haddr[31] |=> !ms_hready)
      else $error("no wait state");
   a_wr_oe: assert property ($rose(mx_hd_oe) |-> $past(mx_hwrite))
      else $error("pads driven on read");
   a_done_bound: assert property (lo_r < 11'h3fc)
      else $error("transfer never ends");
   a_err_two: assert property (ms_hresp == 2'h1 && !ms_hready |=> ms_hresp == 2'h1 && ms_hready)
      else $error("error second cycle lost");
   a_err_first: assert property ($rose(ms_hready) && ms_hresp == 2'h1 |-> $past(ms_hresp) == 2'h1)
      else $error("error first cycle lost");
endmodule

// *** aob_far_slave.sv ***
// aob_far_slave.sv: far ahb slave and arbiter
// assumes 1:1 mode on mclk
`timescale 1ns/10ps
module aob_far_slave (
   input wire         mclk,
   input wire [31:0]  mx_haddr,
   input wire [1:0]   mx_htrans,
   input wire         mx_hbusreq,
   input wire         mx_hd_oe,
   input wire [31:0]  mx_hd_out,
   input wire         slow,
   input wire         err,
   output wire        mx_hgrant,
   output wire        mx_hready,
   output wire [1:0]  mx_hresp,
   output wire [31:0] mx_hd_in
);
   reg        dph_r = 1'h0;
   reg        st_r = 1'h0;
   reg [31:0] a_r = 32'h0;
   reg [31:0] pat_r = 32'h0;
   // idle pads show a moving pattern
   assign mx_hgrant = mx_hbusreq;
   assign mx_hready = !dph_r || !slow || st_r;
   assign mx_hresp = dph_r && err ? 2'h1 : 2'h0;
   assign mx_hd_in = mx_hd_oe ? mx_hd_out : dph_r ? ~a_r : pat_r;
   // one wait when slow
   always @(posedge mclk) begin
      pat_r <= pat_r + 32'h01010101;
      st_r <= dph_r && !mx_hready;
      dph_r <= mx_hready ? mx_htrans[1] : dph_r;
      a_r <= mx_hready ? mx_haddr : a_r;
   end
endmodule

// *** tb_top.sv ***
// tb_top.sv: config register and master bridge bench
// needs aob_top, aob_far_slave, aob_props
`timescale 1ns/10ps
module tb_top;
   logic        mclk='0, rst_n='0, x_hclk='0, slow='0, err='0, awvalid='0, wvalid='0;
   logic        bready='0, arvalid='0, rready='0, ms_hsel='0, ms_hwrite='0, ms_hready_in='1;
   logic        sx_hsel='0, sx_hwrite='0, sx_hready_in='1, sm_hready='1;
   logic [7:0]  awaddr='0, araddr='0;
   logic [3:0]  wstrb='1;
   logic [1:0]  ms_htrans='0, sx_htrans='0, sm_hresp='0;
   logic [2:0]  ms_hsize=3'h2, ms_hburst='0, sx_hsize=3'h2, sx_hburst='0, seen_b;
   logic [31:0] wdata='0, ms_haddr='0, ms_hwdata='0, sx_haddr='0, sx_hwdata='0, sm_hrdata='0, seen_wd;
   logic [31:0] cv[6]='{32'h4, 32'h8, 32'h38, 32'h40, 32'h44, 32'h0};
   logic [1:0]  cm[6]='{2'h0, 2'h1, 2'h1, 2'h3, 2'h0, 2'h2};
   wire         awready, wready, bvalid, arready, rvalid, mx_hwrite, mx_ctl_oe, mx_hd_oe, mx_hbusreq;
   wire         mx_hgrant, mx_hready, sx_hready, sx_resp_oe, sm_hwrite, ms_hready;
   wire [1:0]   bresp, rresp, mx_htrans, mx_hresp, sx_hresp, sm_htrans, bridge_mode_code, ms_hresp;
   wire [2:0]   mx_hsize, mx_hburst, sm_hsize, sm_hburst;
   wire [31:0]  rdata, mx_haddr, mx_hd_in, mx_hd_out, sx_hrdata, sm_haddr, sm_hwdata, ms_hrdata;
   int          miscompares=0, checks=0;
   aob_top dut_u (.*);
   aob_far_slave far_u (.*);
   initial forever #5 mclk = ~mclk;
   initial #3 forever #62.5 x_hclk = ~x_hclk;
   // far bus record
   always @(posedge mclk) begin
      if (mx_htrans == 2'h2) seen_b <= mx_hburst;
      if (mx_hd_oe) seen_wd <= mx_hd_out;
   end
   task automatic chk(input string n, input [31:0] e, input [31:0] s);
      checks++;
      if (s !== e) begin
         miscompares++;
         $display("CHECK FAILED %s exp %h got %h", n, e, s);
      end
   endtask
   // aw and w offered together
   task automatic axw(input [7:0] a, input [31:0] d, input [1:0] er);
      @(posedge mclk);
      awaddr <= a; wdata <= d; awvalid <= '1; wvalid <= '1; bready <= '1;
      fork
         begin do @(posedge mclk); while (!awready); awvalid <= '0; end
         begin do @(posedge mclk); while (!wready); wvalid <= '0; end
      join
      while (!bvalid) @(posedge mclk);
      bready <= '0;
      chk("bresp", er, bresp);
   endtask
   task automatic axr(input [7:0] a, input [31:0] e, input [1:0] er);
      @(posedge mclk);
      araddr <= a; arvalid <= '1; rready <= '1;
      do @(posedge mclk); while (!arready);
      arvalid <= '0;
      do @(posedge mclk); while (!rvalid);
      rready <= '0;
      chk("rdata", e, rdata);
      chk("rresp", er, rresp);
   endtask
   // single beat; the watchdog bounds the wait
   task automatic ahb(input [31:0] a, input w, input [2:0] b, input [1:0] er, input [31:0] d);
      ms_haddr <= a; ms_hwrite <= w; ms_hburst <= b; ms_htrans <= 2'h2; ms_hsel <= '1;
      @(posedge mclk);
      ms_htrans <= '0; ms_hsel <= '0; ms_hwdata <= d;
      do @(posedge mclk); while (ms_hready !== 1'b1);
      chk("hresp", er, ms_hresp);
      if (!w && er == 2'h0) chk("hrdata", d, ms_hrdata);
   endtask
   task automatic close_out;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge mclk);
      rst_n <= '1;
      repeat (3) @(posedge mclk);
      axr(8'h08, 32'h80000000, 2'h0);
      axr(8'h04, 32'h2, 2'h0);
      axr(8'h40, 32'h0, 2'h3);
      axw(8'h41, 32'h7, 2'h3);
      $display("regs done");
      foreach (cv[i]) begin
         axw(8'h00, cv[i], 2'h0);
         @(posedge mclk);
         chk("mode", cm[i], bridge_mode_code);
      end
      $display("modes done");
      ahb(32'h80000010, 1'h0, 3'h0, 2'h0, ~32'h80000010);
      ahb(32'h80000020, 1'h1, 3'h0, 2'h0, 32'h12345678);
      chk("wdata", 32'h12345678, seen_wd);
      slow <= '1;
      ahb(32'h80000030, 1'h0, 3'h0, 2'h0, ~32'h80000030);
      err <= '1;
      ahb(32'h80000034, 1'h0, 3'h0, 2'h1, 32'h0);
      err <= '0;
      slow <= '0;
      for (int o = 0; o < 2; o++) begin
         axw(8'h00, o, 2'h0);
         ahb(32'h80000040, 1'h0, 3'h3, 2'h0, ~32'h80000040);
         chk("burst", o ? 3'h1 : 3'h3, seen_b);
      end
      ahb(32'h10000000, 1'h1, 3'h0, 2'h0, 32'h0);
      chk("busreq", 1'h0, mx_hbusreq);
      $display("ahb done");
      close_out;
   end
   // watchdog
   initial begin
      #200000;
      miscompares++;
      close_out;
   end
endmodule
bind aob_top aob_props chk_u (.*);
